// *** design/atl_angle_tracking_loop.sv ***
// Behaviour
// - Source 0: compare threshold with active-to-inactive trigger time.
// - Evaluate direction only on inactive trigger edge, both sources.
// - Threshold zero keeps current direction.
// - Maximum threshold while backward returns forward at next evaluation unless the trigger stays high until width saturates at maximum.
// - Source 1 with map select 0 takes external direction input.
// - Backward status bit: 0 forward, 1 backward.
// - Backward status bit shows reset value while disabled; internal direction kept.
// - Re-enable clears direction only if state edge seen or not emergency.
// - Sync write loads count and previous count from written bits.
`timescale 1ns/1ps
`default_nettype none
module atl_angle_tracking_loop #(
    parameter int THR_W  = atl_pkg::THR_W,
    parameter int SYNC_W = atl_pkg::SYNC_W
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output var  logic [31:0] rdata_o,
    input  wire logic        trigger_i,
    input  wire logic        state_i,
    input  wire logic        external_direction_input_i,
    output var  logic        backward_o
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pins_s;

    atl_sync2 #(.W(3)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({external_direction_input_i, state_i, trigger_i}),
        .q_o       (pins_s)
    );

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic              enable;
        logic              dir_src;
        logic              emerg;
        logic              synchronous_motor_control;
        logic              tmap;
        logic [THR_W-1:0]  threshold;
        logic [SYNC_W-1:0] trig_cnt;
        logic [SYNC_W-1:0] trig_old;
        logic [SYNC_W-1:0] state_cnt;
        logic [SYNC_W-1:0] state_old;
        logic              dir_int;
        logic              fsd;
        logic              trig_d;
        logic              state_d;
        logic [THR_W-1:0]  width;
        logic [31:0]       rdata;
        logic              bwd_out;
    } atl_state_type;

    atl_state_type st_r;
    atl_state_type st_nxt;

    // ---------------------------------------------------------------
    // Local signals
    // ---------------------------------------------------------------
    logic trig_rise;
    logic trig_fall;
    logic state_rise;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    always_comb begin
        st_nxt     = st_r;

        // ---------------------------------------------------------------
        // Edge detection
        // ---------------------------------------------------------------
        trig_rise  = pins_s[0] && !st_r.trig_d;
        trig_fall  = !pins_s[0] && st_r.trig_d;
        state_rise = pins_s[1] && !st_r.state_d;
        st_nxt.trig_d  = pins_s[0];
        st_nxt.state_d = pins_s[1];

        // ---------------------------------------------------------------
        // Control and status words
        // ---------------------------------------------------------------
        ctrl_word = atl_pkg::ZERO32;
        ctrl_word[atl_pkg::CTRL_ENABLE]  = st_r.enable;
        ctrl_word[atl_pkg::CTRL_DIR_SRC] = st_r.dir_src;
        ctrl_word[atl_pkg::CTRL_EMERG]   = st_r.emerg;
        ctrl_word[atl_pkg::CTRL_SMC]     = st_r.synchronous_motor_control;
        ctrl_word[atl_pkg::CTRL_TMAP]    = st_r.tmap;

        stat_word = atl_pkg::ZERO32;
        stat_word[atl_pkg::STAT_BWD] = st_r.bwd_out;
        stat_word[atl_pkg::STAT_FSD] = st_r.fsd;

        // ---------------------------------------------------------------
        // Direction evaluation
        // ---------------------------------------------------------------
        if (st_r.enable) begin
            // Count cycles while trigger stands high
            if (pins_s[0] && st_r.width != '1) begin
                st_nxt.width = st_r.width + 1'b1;
            end
            if (trig_rise) begin
                st_nxt.width = THR_W'(1);
            end
            if (state_rise) begin
                st_nxt.fsd = 1'b1;
            end
            if (trig_fall) begin
                if (st_r.dir_src && !st_r.tmap) begin
                    st_nxt.dir_int = pins_s[2];
                end else if (!st_r.dir_src) begin
                    if (st_r.threshold != '0) begin
                        // Width against threshold; width at or above threshold (max included) gives backward
                        st_nxt.dir_int = (st_r.width >= st_r.threshold);
                    end
                end
            end
        end

        // ---------------------------------------------------------------
        // Register writes
        // ---------------------------------------------------------------
        if (wr_i) begin
            unique case (addr_i)
                atl_pkg::ADDR_CTRL: begin
                    st_nxt.enable  = wdata_i[atl_pkg::CTRL_ENABLE];
                    st_nxt.dir_src = wdata_i[atl_pkg::CTRL_DIR_SRC];
                    st_nxt.emerg   = wdata_i[atl_pkg::CTRL_EMERG];
                    st_nxt.synchronous_motor_control     = wdata_i[atl_pkg::CTRL_SMC];
                    st_nxt.tmap    = wdata_i[atl_pkg::CTRL_TMAP];
                    if (wdata_i[atl_pkg::CTRL_ENABLE] && !st_r.enable) begin
                        if (st_r.fsd || !wdata_i[atl_pkg::CTRL_EMERG]) begin
                            st_nxt.dir_int = 1'b0;
                        end
                        st_nxt.fsd = 1'b0;
                    end
                end
                atl_pkg::ADDR_THRESHOLD: begin
                    st_nxt.threshold = wdata_i[THR_W-1:0];
                end
                atl_pkg::ADDR_TRIG_CNT: begin
                    if (wdata_i[atl_pkg::SYNC_WEN_BIT]) begin
                        st_nxt.trig_cnt = wdata_i[atl_pkg::SYNC_LO +: SYNC_W];
                        st_nxt.trig_old = wdata_i[atl_pkg::SYNC_OLD_LO +: SYNC_W];
                    end
                end
                atl_pkg::ADDR_STATE_CNT: begin
                    if (wdata_i[atl_pkg::SYNC_WEN_BIT]) begin
                        st_nxt.state_cnt = wdata_i[atl_pkg::SYNC_LO +: SYNC_W];
                        st_nxt.state_old = wdata_i[atl_pkg::SYNC_OLD_LO +: SYNC_W];
                    end
                end
                default: begin
                end
            endcase
        end

        // ---------------------------------------------------------------
        // Status output
        // ---------------------------------------------------------------
        // Status hides direction while disabled
        st_nxt.bwd_out = st_nxt.enable && st_nxt.dir_int;

        // ---------------------------------------------------------------
        // Register reads
        // ---------------------------------------------------------------
        st_nxt.rdata = atl_pkg::ZERO32;
        if (rd_i) begin
            unique case (addr_i)
                atl_pkg::ADDR_CTRL:      st_nxt.rdata = ctrl_word;
                atl_pkg::ADDR_THRESHOLD: st_nxt.rdata = 32'(st_r.threshold);
                atl_pkg::ADDR_STATUS:    st_nxt.rdata = stat_word;
                atl_pkg::ADDR_TRIG_CNT: begin
                    st_nxt.rdata[atl_pkg::SYNC_LO +: SYNC_W]     = st_r.trig_cnt;
                    st_nxt.rdata[atl_pkg::SYNC_OLD_LO +: SYNC_W] = st_r.trig_old;
                end
                atl_pkg::ADDR_STATE_CNT: begin
                    st_nxt.rdata[atl_pkg::SYNC_LO +: SYNC_W]     = st_r.state_cnt;
                    st_nxt.rdata[atl_pkg::SYNC_OLD_LO +: SYNC_W] = st_r.state_old;
                end
                default: st_nxt.rdata = atl_pkg::ZERO32;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // Reset to forward
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata_o    = st_r.rdata;
    assign backward_o = st_r.bwd_out;
endmodule
`default_nettype wire

// *** design/atl_pkg.sv ***
`default_nettype none
package atl_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_THRESHOLD = 4'h1;
    localparam logic [3:0]  ADDR_STATUS    = 4'h2;
    localparam logic [3:0]  ADDR_TRIG_CNT  = 4'h3;
    localparam logic [3:0]  ADDR_STATE_CNT = 4'h4;

    // Control fields
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_DIR_SRC  = 1;
    localparam int CTRL_EMERG    = 2;
    localparam int CTRL_SMC      = 3;
    localparam int CTRL_TMAP     = 4;

    // Sync count fields: count in [7:0], previous in [15:8], write enable bit 31
    localparam int SYNC_W        = 8;
    localparam int SYNC_LO       = 0;
    localparam int SYNC_OLD_LO   = 8;
    localparam int SYNC_WEN_BIT  = 31;

    // Status fields
    localparam int STAT_BWD      = 0;
    localparam int STAT_FSD      = 1;

    localparam int THR_W         = 24;
    localparam logic [23:0] THR_RESET = 24'h00_0000;
    localparam logic [31:0] ZERO32    = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] addr_pad;
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } atl_bus_type;

endpackage
`default_nettype wire

// *** design/atl_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module atl_sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** verification/atl_angle_tracking_loop_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module atl_angle_tracking_loop_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        trig;
    logic        st;
    logic        ext;
    logic        bwd;
    int          miscompares = 0;
    int          total_checks = 0;
    int          dir_m = 0;
    int          thr;
    int          w;
    int unsigned seed = 36;
    initial forever #2 clk = ~clk;
    atl_angle_tracking_loop atl_angle_tracking_loop_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .trigger_i(trig), .state_i(st), .external_direction_input_i(ext), .backward_o(bwd));
    atl_timer_model atl_timer_model_inst (.ref_clk_i(clk), .trigger_o(trig), .state_o(st),
        .ext_dir_o(ext));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wreg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr   <= 1'b1;
        @(posedge clk);
        wr   <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_dir();
        rreg(4'h2);
        `CHK("backward", dir_m[0], bwd)
        `CHK("status", dir_m[0], d[0])
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk_dir();
        wreg(4'h0, 32'h0000_0001);
        wreg(4'h1, 32'h0000_0005);
        fork
            atl_timer_model_inst.pulse(20, 1'b0, 1'b0);
            begin
                repeat (14) @(posedge clk);
                #1 `CHK("early", 1'b0, bwd)
            end
        join
        dir_m = 1;
        chk_dir();
        wreg(4'h1, 32'h0000_0000);
        atl_timer_model_inst.pulse(2, 1'b0, 1'b0);
        chk_dir();
        wreg(4'h1, 32'h00FF_FFFF);
        atl_timer_model_inst.pulse(20, 1'b0, 1'b0);
        dir_m = 0;
        chk_dir();
        for (int i = 0; i < 8; i++) begin
            thr = 8 + xs() % 16;
            w = (xs() & 1) ? thr + xs() % 12 : thr - 1 - xs() % (thr - 4);
            wreg(4'h1, 32'(thr));
            atl_timer_model_inst.pulse(w, 1'b0, 1'b0);
            dir_m = int'(w >= thr);
            chk_dir();
        end
        wreg(4'h0, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            dir_m = xs() & 1;
            atl_timer_model_inst.pulse(3, dir_m[0], 1'b0);
            chk_dir();
        end
        wreg(4'h0, 32'h0000_001B);
        rreg(4'h0);
        `CHK("control", 32'h0000_001B, d)
        atl_timer_model_inst.pulse(3, ~dir_m[0], 1'b0);
        chk_dir();
        wreg(4'h0, 32'h0000_0001);
        wreg(4'h1, 32'h0000_0005);
        for (int k = 0; k < 3; k++) begin
            atl_timer_model_inst.pulse(20, 1'b0, k == 1);
            wreg(4'h0, 32'h0000_0000);
            rreg(4'h2);
            `CHK("off", 1'b0, d[0])
            `CHK("off pin", 1'b0, bwd)
            `CHK("first state", (k == 1), d[1])
            wreg(4'h0, (k == 2) ? 32'h0000_0001 : 32'h0000_0005);
            dir_m = int'(k == 0);
            chk_dir();
        end
        for (int i = 0; i < 2; i++) begin
            d = xs();
            thr = d;
            wreg(4'(3 + i), {1'b1, d[30:0]});
            wreg(4'(3 + i), {1'b0, ~d[30:0]});
            rreg(4'(3 + i));
            `CHK("sync", (thr & 32'h0000_FFFF), d)
        end
        rreg(4'hF);
        `CHK("unmapped", 32'h0000_0000, d)
        give_verdict();
    end
endmodule
bind atl_angle_tracking_loop atl_loop_chk atl_loop_chk_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .trigger_i(trigger_i), .backward_o(backward_o));
`default_nettype wire

// *** verification/atl_loop_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module atl_loop_chk (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        trigger_i,
    input wire logic        backward_o
);
    logic        en_r;
    logic        src_r;
    logic [23:0] thr_r;
    logic [15:0] cnt_trig_r;
    logic [15:0] cnt_state_r;
    logic [15:0] cnt_sel;
    assign cnt_sel = addr_i[2] ? cnt_state_r : cnt_trig_r;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            en_r        <= 1'b0;
            src_r       <= 1'b0;
            thr_r       <= 24'h00_0000;
            cnt_trig_r  <= 16'h0000;
            cnt_state_r <= 16'h0000;
        end else if (wr_i) begin
            if (addr_i == 4'h0) begin
                en_r  <= wdata_i[0];
                src_r <= wdata_i[1];
            end
            if (addr_i == 4'h1)
                thr_r <= wdata_i[23:0];
            if (addr_i == 4'h3 && wdata_i[31])
                cnt_trig_r <= wdata_i[15:0];
            if (addr_i == 4'h4 && wdata_i[31])
                cnt_state_r <= wdata_i[15:0];
        end
    end
    a_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0000_0000) else $error("rdata not idle");
    a_status_bit: assert property (
        rd_i && addr_i == 4'h2 |=> rdata_o[0] == $past(backward_o)) else $error("status bit");
    a_off_clear: assert property (
        !en_r && !$past(en_r) |-> !backward_o) else $error("backward while off");
    a_trig_hold: assert property (
        (trigger_i && !wr_i) [*4] |-> $stable(backward_o)) else $error("early change");
    a_zero_keep: assert property (
        thr_r == 24'h00_0000 && !src_r && !wr_i && !$past(wr_i) |=> $stable(backward_o))
        else $error("zero threshold change");
    a_thr_read: assert property (
        rd_i && addr_i == 4'h1 |=> rdata_o == {8'h00, $past(thr_r)}) else $error("threshold");
    a_sync_load: assert property (
        rd_i && (addr_i == 4'h3 || addr_i == 4'h4) |=> rdata_o[15:0] == $past(cnt_sel))
        else $error("sync count");
    a_unmapped_zero: assert property (
        rd_i && addr_i > 4'h4 |=> rdata_o == 32'h0000_0000) else $error("unmapped read");
endmodule
`default_nettype wire

// *** verification/atl_timer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module atl_timer_model (
    input  wire logic ref_clk_i,
    output var  logic trigger_o,
    output var  logic state_o,
    output var  logic ext_dir_o
);
    initial begin
        trigger_o = 1'b0;
        state_o   = 1'b0;
        ext_dir_o = 1'b0;
    end
    task automatic pulse(input int w, input logic ext, input logic st);
        @(posedge ref_clk_i);
        ext_dir_o <= ext;
        trigger_o <= 1'b1;
        state_o   <= st;
        repeat (w) @(posedge ref_clk_i);
        trigger_o <= 1'b0;
        state_o   <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask
endmodule
`default_nettype wire
